/* design/pdm_cic.sv */
// Second-order CIC decimator for a one-bit stream, one channel.
// Assumes the caller marks each input bit and each output instant with pulses.
`timescale 1ns/10ps
module pdm_cic #(
    parameter int W = pdm_pkg::CIC_W,
    parameter int OUT_W = pdm_pkg::AUDIO_W
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic clear_i,
    input wire logic in_valid_i,
    input wire logic in_bit_i,
    input wire logic dump_i,
    input wire logic [2:0] shift_i,
    output logic [OUT_W-1:0] out_data_o
);
    localparam logic signed [W-1:0] STEP = W'(1);

    logic signed [W-1:0] int1_ff;
    logic signed [W-1:0] int2_ff;
    logic signed [W-1:0] dly1_ff;
    logic signed [W-1:0] dly2_ff;
    logic signed [W-1:0] nxt_int1;
    logic signed [W-1:0] nxt_int2;
    logic signed [W-1:0] comb1;
    logic signed [W-1:0] comb2;
    logic signed [W-1:0] scaled;

    // The comb stage sees the integrator value including a bit that lands in
    // the same cycle as the dump, so no bit of the frame is lost.
    always_comb begin
        nxt_int1 = int1_ff;
        nxt_int2 = int2_ff;
        if (in_valid_i) begin
            nxt_int1 = in_bit_i ? int1_ff + STEP : int1_ff - STEP;
            nxt_int2 = int2_ff + nxt_int1;
        end
        comb1 = nxt_int2 - dly1_ff;
        comb2 = comb1 - dly2_ff;
        scaled = comb2 <<< shift_i;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i || clear_i) begin
            int1_ff <= '0;
            int2_ff <= '0;
            dly1_ff <= '0;
            dly2_ff <= '0;
            out_data_o <= '0;
        end else begin
            int1_ff <= nxt_int1;
            int2_ff <= nxt_int2;
            if (dump_i) begin
                dly1_ff <= nxt_int2;
                dly2_ff <= comb1;
                out_data_o <= scaled[OUT_W-1:0];
            end
        end
    end
endmodule

/* design/pdm_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two and both sides share one clock.
`timescale 1ns/10ps
module pdm_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    assign in_ready_o = count_ff != (AW+1)'(DEPTH);
    assign out_valid_o = count_ff != '0;
    assign out_data_o = mem[rd_ptr_ff];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule

/* design/pdm_mic_top.sv */
// Digital microphone input path: register file, microphone clock generator,
// bit-stream capture, source selection, two decimators and an output FIFO.
// Assumes one 100 MHz clock, a one-cycle register port and a host that
// drains stereo words with a valid/ready handshake.
//
// Summary of operation
// - Mode field 00 disables microphone input; 01, 10, 11 select ratios 128, 64, 32.
// - With microphone mode on, filters take the external stream, not the modulator.
// - Captured bits are decimated and audio words go out to the host.
// - Pin one function 1010 drives the microphone clock on that pin.
// - Pin two function 0101 samples microphone data on clock rising edges.
// - Pin two function 0110 samples microphone data on clock falling edges.
// - Pin two function 0111 samples microphone data on both clock edges.
// - Bit 2 of each channel power register powers that channel down or up.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
module pdm_mic_top #(
    parameter int SAMPLE_RATE_HZ = pdm_pkg::SAMPLE_RATE_HZ,
    parameter int FIFO_DEPTH = pdm_pkg::FIFO_DEPTH
) (
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic [pdm_pkg::ADDR_W-1:0] REG_ADDR_I,
    input wire logic [pdm_pkg::DATA_W-1:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [pdm_pkg::DATA_W-1:0] REG_RDATA_O,
    output logic MIC_CLOCK_OUT_PIN_O,
    output logic MIC_CLOCK_OUT_PIN_OE_O,
    input wire logic MIC_BITSTREAM_IN_PIN_I,
    input wire logic MOD_STROBE_I,
    input wire logic MOD_LEFT_BIT_I,
    input wire logic MOD_RIGHT_BIT_I,
    output logic AUDIO_VALID_O,
    output logic [pdm_pkg::AUDIO_W-1:0] AUDIO_LEFT_O,
    output logic [pdm_pkg::AUDIO_W-1:0] AUDIO_RIGHT_O,
    input wire logic AUDIO_READY_I
);
    localparam int WORD_W = 2 * pdm_pkg::AUDIO_W;

    // ==================================================================
    // Helper functions

    function automatic logic [7:0] osr_of(input logic [1:0] mode);
        logic [7:0] r;
        r = pdm_pkg::OSR_128;
        unique case (mode)
            pdm_pkg::MIC_OSR64: r = pdm_pkg::OSR_64;
            pdm_pkg::MIC_OSR32: r = pdm_pkg::OSR_32;
            default: r = pdm_pkg::OSR_128;
        endcase
        return r;
    endfunction

    // Output scaling keeps full scale at the same level for every ratio.
    function automatic logic [2:0] shift_of(input logic [1:0] mode);
        logic [2:0] r;
        r = pdm_pkg::SHIFT_128;
        unique case (mode)
            pdm_pkg::MIC_OSR64: r = pdm_pkg::SHIFT_64;
            pdm_pkg::MIC_OSR32: r = pdm_pkg::SHIFT_32;
            default: r = pdm_pkg::SHIFT_128;
        endcase
        return r;
    endfunction

    // Half period of the microphone clock in system cycles, rounded down and
    // never below one, so the clock is at least ratio times sample rate.
    function automatic logic [pdm_pkg::DIV_W-1:0] half_of(input logic [1:0] mode);
        int h;
        h = pdm_pkg::CLK_HZ / (2 * int'(osr_of(mode)) * SAMPLE_RATE_HZ);
        if (h < 1) begin
            h = 1;
        end
        return h[pdm_pkg::DIV_W-1:0];
    endfunction

    function automatic pdm_pkg::pdm_cap_t cap_of(input logic [3:0] func);
        pdm_pkg::pdm_cap_t r;
        r = pdm_pkg::CAP_NONE;
        unique case (func)
            pdm_pkg::FUNC_DATA_RISE: r = pdm_pkg::CAP_RISE;
            pdm_pkg::FUNC_DATA_FALL: r = pdm_pkg::CAP_FALL;
            pdm_pkg::FUNC_DATA_BOTH: r = pdm_pkg::CAP_BOTH;
            default: r = pdm_pkg::CAP_NONE;
        endcase
        return r;
    endfunction

    // ==================================================================
    // Register file

    logic [7:0] mic_ctrl_ff;
    logic [7:0] left_pwr_ff;
    logic [7:0] right_pwr_ff;
    logic [7:0] pin1_func_ff;
    logic [7:0] pin2_func_ff;
    logic overrun_ff;
    logic [7:0] status_byte;
    logic [7:0] nxt_rdata;
    logic overrun_set;
    logic overrun_clr;

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            mic_ctrl_ff <= pdm_pkg::RESET_BYTE;
            left_pwr_ff <= pdm_pkg::RESET_BYTE;
            right_pwr_ff <= pdm_pkg::RESET_BYTE;
            pin1_func_ff <= pdm_pkg::RESET_BYTE;
            pin2_func_ff <= pdm_pkg::RESET_BYTE;
        end else if (REG_WR_I) begin
            unique case (REG_ADDR_I)
                pdm_pkg::REG_MIC_CTRL: mic_ctrl_ff <= REG_WDATA_I;
                pdm_pkg::REG_LEFT_PWR: left_pwr_ff <= REG_WDATA_I;
                pdm_pkg::REG_RIGHT_PWR: right_pwr_ff <= REG_WDATA_I;
                pdm_pkg::REG_PIN1_FUNC: pin1_func_ff <= REG_WDATA_I;
                pdm_pkg::REG_PIN2_FUNC: pin2_func_ff <= REG_WDATA_I;
                default: ;
            endcase
        end
    end

    // A word lost in the same cycle as a clear still leaves the flag set.
    assign overrun_clr = REG_WR_I && REG_ADDR_I == pdm_pkg::REG_STATUS && REG_WDATA_I[pdm_pkg::STAT_OVERRUN];

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            overrun_ff <= 1'b0;
        end else begin
            overrun_ff <= overrun_set || (overrun_ff && !overrun_clr);
        end
    end

    // ==================================================================
    // Mode decode

    logic [1:0] mic_mode;
    logic mic_on;
    logic clk_drive;
    logic left_on;
    logic right_on;
    pdm_pkg::pdm_cap_t cap_mode;
    logic [7:0] frame_len;
    logic [pdm_pkg::DIV_W-1:0] half_len;
    logic fifo_in_ready;
    logic fifo_out_valid;

    assign mic_mode = mic_ctrl_ff[pdm_pkg::MODE_MSB:pdm_pkg::MODE_LSB];
    assign mic_on = mic_mode != pdm_pkg::MIC_OFF;
    assign clk_drive = mic_on && pin1_func_ff[pdm_pkg::FUNC_MSB:pdm_pkg::FUNC_LSB] == pdm_pkg::FUNC_MIC_CLK;
    assign cap_mode = cap_of(pin2_func_ff[pdm_pkg::FUNC_MSB:pdm_pkg::FUNC_LSB]);
    assign left_on = left_pwr_ff[pdm_pkg::PWR_BIT];
    assign right_on = right_pwr_ff[pdm_pkg::PWR_BIT];
    assign frame_len = mic_on ? osr_of(mic_mode) : pdm_pkg::OSR_INTERNAL;
    assign half_len = half_of(mic_mode);

    assign status_byte = {4'h0, clk_drive, !fifo_out_valid, mic_on, overrun_ff};

    always_comb begin
        nxt_rdata = '0;
        if (REG_RD_I) begin
            unique case (REG_ADDR_I)
                pdm_pkg::REG_MIC_CTRL: nxt_rdata = mic_ctrl_ff;
                pdm_pkg::REG_LEFT_PWR: nxt_rdata = left_pwr_ff;
                pdm_pkg::REG_RIGHT_PWR: nxt_rdata = right_pwr_ff;
                pdm_pkg::REG_PIN1_FUNC: nxt_rdata = pin1_func_ff;
                pdm_pkg::REG_PIN2_FUNC: nxt_rdata = pin2_func_ff;
                pdm_pkg::REG_STATUS: nxt_rdata = status_byte;
                default: nxt_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            REG_RDATA_O <= '0;
        end else begin
            REG_RDATA_O <= nxt_rdata;
        end
    end

    // ==================================================================
    // Microphone clock generator

    logic [pdm_pkg::DIV_W-1:0] div_cnt_ff;
    logic mclk_ff;
    logic half_done;
    logic rise_evt;
    logic fall_evt;

    assign half_done = mic_on && div_cnt_ff >= half_len - 1'b1;
    assign rise_evt = half_done && !mclk_ff;
    assign fall_evt = half_done && mclk_ff;

    always_ff @(posedge CLK_I) begin
        if (SRST_I || !mic_on) begin
            div_cnt_ff <= '0;
            mclk_ff <= 1'b0;
        end else if (half_done) begin
            div_cnt_ff <= '0;
            mclk_ff <= !mclk_ff;
        end else begin
            div_cnt_ff <= div_cnt_ff + 1'b1;
        end
    end

    // The pin copies the internal clock through its own flop; the enable is
    // dropped whenever the pin is not assigned to the microphone clock.
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            MIC_CLOCK_OUT_PIN_O <= 1'b0;
            MIC_CLOCK_OUT_PIN_OE_O <= 1'b0;
        end else begin
            MIC_CLOCK_OUT_PIN_O <= clk_drive && (rise_evt ? 1'b1 : (fall_evt ? 1'b0 : mclk_ff));
            MIC_CLOCK_OUT_PIN_OE_O <= clk_drive;
        end
    end

    // ==================================================================
    // Bit-stream capture

    logic data_meta_ff;
    logic data_sync_ff;

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            data_meta_ff <= 1'b0;
            data_sync_ff <= 1'b0;
        end else begin
            data_meta_ff <= MIC_BITSTREAM_IN_PIN_I;
            data_sync_ff <= data_meta_ff;
        end
    end

    // In single-edge modes the same bit feeds both filters, so whichever
    // channel software powered carries the microphone.
    logic mic_left_valid;
    logic mic_right_valid;
    logic left_valid;
    logic right_valid;
    logic left_bit;
    logic right_bit;

    always_comb begin
        mic_left_valid = 1'b0;
        mic_right_valid = 1'b0;
        unique case (cap_mode)
            pdm_pkg::CAP_RISE: begin
                mic_left_valid = rise_evt;
                mic_right_valid = rise_evt;
            end
            pdm_pkg::CAP_FALL: begin
                mic_left_valid = fall_evt;
                mic_right_valid = fall_evt;
            end
            pdm_pkg::CAP_BOTH: begin
                mic_left_valid = rise_evt;
                mic_right_valid = fall_evt;
            end
            pdm_pkg::CAP_NONE: begin
                mic_left_valid = 1'b0;
                mic_right_valid = 1'b0;
            end
        endcase
    end

    // Source switch: the internal modulator is cut off while microphone mode is on.
    assign left_valid = mic_on ? mic_left_valid : MOD_STROBE_I;
    assign right_valid = mic_on ? mic_right_valid : MOD_STROBE_I;
    assign left_bit = mic_on ? data_sync_ff : MOD_LEFT_BIT_I;
    assign right_bit = mic_on ? data_sync_ff : MOD_RIGHT_BIT_I;

    // ==================================================================
    // Frame counter: one output word per ratio clock periods

    logic [7:0] frame_cnt_ff;
    logic frame_tick;
    logic dump;
    logic dump_d_ff;
    logic mic_on_d_ff;

    assign frame_tick = mic_on ? fall_evt : MOD_STROBE_I;
    assign dump = frame_tick && frame_cnt_ff >= frame_len - 1'b1;

    always_ff @(posedge CLK_I) begin
        if (SRST_I || mic_on != mic_on_d_ff) begin
            frame_cnt_ff <= '0;
        end else if (dump) begin
            frame_cnt_ff <= '0;
        end else if (frame_tick) begin
            frame_cnt_ff <= frame_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            dump_d_ff <= 1'b0;
            mic_on_d_ff <= 1'b0;
        end else begin
            dump_d_ff <= dump;
            mic_on_d_ff <= mic_on;
        end
    end

    // ==================================================================
    // Decimation filters

    logic [pdm_pkg::AUDIO_W-1:0] left_word;
    logic [pdm_pkg::AUDIO_W-1:0] right_word;
    logic [2:0] shift;

    assign shift = mic_on ? shift_of(mic_mode) : pdm_pkg::SHIFT_128;

    // A powered-down channel holds its filter cleared and contributes zero.
    pdm_cic u_cic_left (
        .clk_i(CLK_I),
        .srst_i(SRST_I),
        .clear_i(!left_on),
        .in_valid_i(left_valid),
        .in_bit_i(left_bit),
        .dump_i(dump),
        .shift_i(shift),
        .out_data_o(left_word)
    );

    pdm_cic u_cic_right (
        .clk_i(CLK_I),
        .srst_i(SRST_I),
        .clear_i(!right_on),
        .in_valid_i(right_valid),
        .in_bit_i(right_bit),
        .dump_i(dump),
        .shift_i(shift),
        .out_data_o(right_word)
    );

    // ==================================================================
    // Output FIFO and host stage

    logic push_req;
    logic fifo_out_ready;
    logic [WORD_W-1:0] fifo_out_data;

    // A full FIFO drops the new word rather than stalling the filters,
    // because the bit stream cannot be paused; the loss is flagged.
    assign push_req = dump_d_ff && (left_on || right_on);
    assign overrun_set = push_req && !fifo_in_ready;
    assign fifo_out_ready = !AUDIO_VALID_O || AUDIO_READY_I;

    pdm_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(CLK_I),
        .srst_i(SRST_I),
        .in_valid_i(push_req),
        .in_data_i({left_word, right_word}),
        .in_ready_o(fifo_in_ready),
        .out_valid_o(fifo_out_valid),
        .out_data_o(fifo_out_data),
        .out_ready_i(fifo_out_ready)
    );

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            AUDIO_VALID_O <= 1'b0;
            AUDIO_LEFT_O <= '0;
            AUDIO_RIGHT_O <= '0;
        end else if (fifo_out_ready) begin
            AUDIO_VALID_O <= fifo_out_valid;
            AUDIO_LEFT_O <= fifo_out_data[WORD_W-1:pdm_pkg::AUDIO_W];
            AUDIO_RIGHT_O <= fifo_out_data[pdm_pkg::AUDIO_W-1:0];
        end
    end

endmodule

/* design/pdm_pkg.sv */
// Constants, register map and types shared by the microphone input path.
// Assumes a single 100 MHz system clock and an 8-bit register port.
package pdm_pkg;

    // ==================================================================
    // Register map
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] REG_MIC_CTRL = 8'h08;
    localparam logic [7:0] REG_LEFT_PWR = 8'h13;
    localparam logic [7:0] REG_RIGHT_PWR = 8'h16;
    localparam logic [7:0] REG_PIN1_FUNC = 8'h62;
    localparam logic [7:0] REG_PIN2_FUNC = 8'h63;
    localparam logic [7:0] REG_STATUS = 8'h70;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // ==================================================================
    // Field positions and codes
    localparam int MODE_MSB = 1;
    localparam int MODE_LSB = 0;
    localparam int PWR_BIT = 2;
    localparam int FUNC_MSB = 7;
    localparam int FUNC_LSB = 4;
    localparam logic [1:0] MIC_OFF = 2'h0;
    localparam logic [1:0] MIC_OSR128 = 2'h1;
    localparam logic [1:0] MIC_OSR64 = 2'h2;
    localparam logic [1:0] MIC_OSR32 = 2'h3;
    localparam logic [3:0] FUNC_MIC_CLK = 4'hA;
    localparam logic [3:0] FUNC_DATA_RISE = 4'h5;
    localparam logic [3:0] FUNC_DATA_FALL = 4'h6;
    localparam logic [3:0] FUNC_DATA_BOTH = 4'h7;
    localparam int STAT_OVERRUN = 0;
    localparam int STAT_MIC_ACTIVE = 1;
    localparam int STAT_FIFO_EMPTY = 2;
    localparam int STAT_CLK_DRIVE = 3;

    // ==================================================================
    // Ratios, widths and timing
    localparam logic [7:0] OSR_128 = 8'h80;
    localparam logic [7:0] OSR_64 = 8'h40;
    localparam logic [7:0] OSR_32 = 8'h20;
    localparam logic [7:0] OSR_INTERNAL = 8'h80;
    localparam logic [2:0] SHIFT_128 = 3'h0;
    localparam logic [2:0] SHIFT_64 = 3'h2;
    localparam logic [2:0] SHIFT_32 = 3'h4;
    localparam int AUDIO_W = 16;
    localparam int CIC_W = 18;
    localparam int FIFO_DEPTH = 8;
    localparam int DIV_W = 16;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
    localparam int SAMPLE_RATE_HZ = 48000;

    typedef enum logic [1:0] {CAP_NONE, CAP_RISE, CAP_FALL, CAP_BOTH} pdm_cap_t;

endpackage

/* testbench/pdm_mic_model.sv */
// Behavioural one-bit microphone pair sharing one data line.
// Assumes the clock pin idles low whenever it is not driven.
`timescale 1ns/10ps
module pdm_mic_model (
    input wire logic clk_i,
    input wire logic oe_i,
    input wire logic left_bit_i,
    input wire logic right_bit_i,
    output logic data_o
);
    // ====
    // Data line driven a little after each clock edge
    initial data_o = 1'b0;
    always @(negedge clk_i) data_o <= #20 left_bit_i;
    always @(posedge clk_i) data_o <= #20 right_bit_i;
    // A stale level must not pass for captured data once the clock is withdrawn.
    always @(negedge oe_i) data_o <= #20 ~data_o;
endmodule

/* testbench/pdm_mic_sva.sv */
// Assertions on the ports of the microphone input top.
// Assumes it is bound to every pdm_mic_top instance.
`timescale 1ns/10ps
module pdm_mic_sva #(
    parameter int SAMPLE_RATE_HZ = 48000
) (
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [7:0] REG_RDATA_O,
    input wire logic MIC_CLOCK_OUT_PIN_O,
    input wire logic MIC_CLOCK_OUT_PIN_OE_O,
    input wire logic AUDIO_VALID_O,
    input wire logic [15:0] AUDIO_LEFT_O,
    input wire logic [15:0] AUDIO_RIGHT_O,
    input wire logic AUDIO_READY_I
);
    // ====
    // Shadow fields and half-period counter
    logic [1:0] mode_ff;
    logic [3:0] fn1_ff;
    logic pin_q_ff;
    logic [7:0] cnt_ff;
    logic [1:0] edg_ff;
    logic chg, oe_exp, mwr;
    int h_exp;
    assign chg = MIC_CLOCK_OUT_PIN_O != pin_q_ff;
    assign mwr = REG_WR_I && REG_ADDR_I == pdm_pkg::REG_MIC_CTRL;
    assign oe_exp = mode_ff != 2'h0 && fn1_ff == pdm_pkg::FUNC_MIC_CLK;
    assign h_exp = pdm_pkg::CLK_HZ / (2 * (256 >> mode_ff) * SAMPLE_RATE_HZ);
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            mode_ff <= 2'h0;
            fn1_ff <= 4'h0;
        end else if (mwr) begin
            mode_ff <= REG_WDATA_I[1:0];
        end else if (REG_WR_I && REG_ADDR_I == pdm_pkg::REG_PIN1_FUNC) begin
            fn1_ff <= REG_WDATA_I[7:4];
        end
    end
    // The first two pin edges after a change of ratio are skipped, since the divider may restart.
    always_ff @(posedge CLK_I) begin
        pin_q_ff <= MIC_CLOCK_OUT_PIN_O;
        cnt_ff <= chg ? 8'h01 : cnt_ff + 8'h01;
        if (SRST_I || !MIC_CLOCK_OUT_PIN_OE_O || mwr) begin
            edg_ff <= 2'h0;
        end else if (chg && edg_ff != 2'h2) begin
            edg_ff <= edg_ff + 2'h1;
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    sequence s_wr;
        REG_WR_I && REG_ADDR_I inside {8'h08, 8'h13, 8'h16, 8'h62, 8'h63};
    endsequence
    sequence s_rd_same;
        REG_RD_I && REG_ADDR_I == $past(REG_ADDR_I);
    endsequence
    AST_RDATA_IDLE: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 8'h00)
        else $error("read data not zero outside a read");
    AST_READBACK: assert property (s_wr ##1 s_rd_same |=> REG_RDATA_O == $past(REG_WDATA_I, 2))
        else $error("register read back differs from write");
    AST_OE_ON: assert property (oe_exp && $past(oe_exp, 3) |-> MIC_CLOCK_OUT_PIN_OE_O)
        else $error("clock pin not driven");
    AST_OE_OFF: assert property (!oe_exp && !$past(oe_exp, 3) |-> !MIC_CLOCK_OUT_PIN_OE_O)
        else $error("clock pin driven when not selected");
    AST_PIN_QUIET: assert property (!MIC_CLOCK_OUT_PIN_OE_O && !$past(MIC_CLOCK_OUT_PIN_OE_O)
        |-> !MIC_CLOCK_OUT_PIN_O)
        else $error("clock pin toggles while not driven");
    AST_MODE_OFF: assert property (mode_ff == 2'h0 && $past(mode_ff == 2'h0, 3) |-> !chg)
        else $error("microphone clock runs in disabled mode");
    AST_HALF: assert property (chg && edg_ff == 2'h2 |-> int'(cnt_ff) == h_exp)
        else $error("microphone clock half period wrong");
    AST_HOLD: assert property (AUDIO_VALID_O && !AUDIO_READY_I
        |=> AUDIO_VALID_O && $stable(AUDIO_LEFT_O) && $stable(AUDIO_RIGHT_O))
        else $error("audio word changed before acceptance");
endmodule

bind pdm_mic_top pdm_mic_sva #(.SAMPLE_RATE_HZ(SAMPLE_RATE_HZ)) u_sva (.CLK_I(CLK_I), .SRST_I(SRST_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_RDATA_O(REG_RDATA_O), .MIC_CLOCK_OUT_PIN_O(MIC_CLOCK_OUT_PIN_O),
    .MIC_CLOCK_OUT_PIN_OE_O(MIC_CLOCK_OUT_PIN_OE_O), .AUDIO_VALID_O(AUDIO_VALID_O),
    .AUDIO_LEFT_O(AUDIO_LEFT_O), .AUDIO_RIGHT_O(AUDIO_RIGHT_O), .AUDIO_READY_I(AUDIO_READY_I));

/* testbench/testbench.sv */
// Bench for the microphone input top: register port, microphone and host.
// Assumes the design package is compiled first.
`timescale 1ns/10ps
module testbench;
    // ====
    // Signals, instances and shared tasks
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rdy = 1'b0;
    logic mstb = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] mcnt = 8'h00;
    logic [7:0] rdata;
    logic pin_clk, pin_oe, valid, mic_data;
    logic [15:0] left, right, l, r;
    int miscompares = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [7:0] regs [5] = '{8'h08, 8'h13, 8'h16, 8'h62, 8'h63};
    // Packed as mode, pin two function, left and right power, left and right class.
    logic [11:0] tc [6] = '{12'h975, 12'h9BA, 12'h9F6, 12'h564, 12'hD51, 12'h179};
    always #5 clk = ~clk;
    pdm_mic_top DUT (.CLK_I(clk), .SRST_I(srst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
        .REG_RD_I(rd), .REG_RDATA_O(rdata), .MIC_CLOCK_OUT_PIN_O(pin_clk), .MIC_CLOCK_OUT_PIN_OE_O(pin_oe),
        .MIC_BITSTREAM_IN_PIN_I(mic_data), .MOD_STROBE_I(mstb), .MOD_LEFT_BIT_I(1'b0), .MOD_RIGHT_BIT_I(1'b1),
        .AUDIO_VALID_O(valid), .AUDIO_LEFT_O(left), .AUDIO_RIGHT_O(right), .AUDIO_READY_I(rdy));
    pdm_mic_model mic (.clk_i(pin_clk), .oe_i(pin_oe), .left_bit_i(1'b1), .right_bit_i(1'b0), .data_o(mic_data));
    task automatic wrap_up;
        $display("miscompares %0d tests_run %0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        mcnt <= mcnt + 8'h01;
        mstb <= mcnt[3:0] == 4'h0;
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [1:0] cls(input logic [15:0] v);
        return (v === 16'h0000) ? 2'h0 : (v[15] ? 2'h2 : 2'h1);
    endfunction
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        rd <= 1'b0;
        #1 chk("rdata", {8'h00, e}, {8'h00, rdata});
    endtask
    task automatic get_word;
        int n;
        n = 0;
        do begin
            @(posedge clk) #1;
            n++;
        end while (valid !== 1'b1 && n < 5000);
        chk("audio valid", 16'h0001, {15'h0000, valid});
        l = left;
        r = right;
        rdy <= 1'b1;
        @(posedge clk);
        rdy <= 1'b0;
    endtask
    // The long flush lets the filter forget the previous setting before a word is judged.
    task automatic cfg(input logic [1:0] m, input logic [3:0] f2, input logic pl, input logic pr);
        bus(1'b1, pdm_pkg::REG_PIN1_FUNC, 8'hA0);
        bus(1'b1, pdm_pkg::REG_PIN2_FUNC, {f2, 4'h0});
        bus(1'b1, pdm_pkg::REG_LEFT_PWR, {5'h00, pl, 2'h0});
        bus(1'b1, pdm_pkg::REG_RIGHT_PWR, {5'h00, pr, 2'h0});
        bus(1'b1, pdm_pkg::REG_MIC_CTRL, {6'h00, m});
        wr <= 1'b0;
        rdy <= 1'b1;
        repeat (4200) @(posedge clk);
        rdy <= 1'b0;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        foreach (regs[i]) rd_chk(regs[i], 8'h00);
        foreach (regs[i]) begin
            bus(1'b1, regs[i], 8'hC4 + 8'(i));
            rd_chk(regs[i], 8'hC4 + 8'(i));
        end
        bus(1'b1, 8'h40, 8'hFF);
        rd_chk(8'h40, 8'h00);
        foreach (tc[i]) begin
            cfg(tc[i][11:10], tc[i][9:6], tc[i][5], tc[i][4]);
            get_word();
            chk("left class", {14'h0, tc[i][3:2]}, {14'h0, cls(l)});
            chk("right class", {14'h0, tc[i][1:0]}, {14'h0, cls(r)});
        end
        #1 chk("clock enable", 16'h0000, {15'h0000, pin_oe});
        cfg(2'h2, 4'h7, 1'b0, 1'b0);
        rd_chk(pdm_pkg::REG_STATUS, 8'h0E);
        bus(1'b1, pdm_pkg::REG_PIN1_FUNC, 8'h00);
        rd_chk(pdm_pkg::REG_PIN1_FUNC, 8'h00);
        repeat (4) @(posedge clk);
        #1 chk("clock enable", 16'h0000, {15'h0000, pin_oe});
        cfg(2'h2, 4'h7, 1'b1, 1'b1);
        repeat (20500) @(posedge clk);
        rd_chk(pdm_pkg::REG_STATUS, 8'h0B);
        repeat (8) get_word();
        rd_chk(pdm_pkg::REG_STATUS, 8'h0F);
        bus(1'b1, pdm_pkg::REG_STATUS, 8'h01);
        rd_chk(pdm_pkg::REG_STATUS, 8'h0E);
        wrap_up();
    end
endmodule
